// *** include/cies_pkg.sv ***
// Shared constants for the instruction execute subset block.
package cies_pkg;
	localparam int          AXI_AW      = 8;
	localparam int          FILE_DEPTH  = 128;
	localparam logic [7:0]  OFS_INSTR   = 8'h00;
	localparam logic [7:0]  OFS_ACC     = 8'h04;
	localparam logic [7:0]  OFS_STATUS  = 8'h08;
	localparam logic [7:0]  OFS_PAGE    = 8'h0c;
	localparam logic [7:0]  OFS_IRQCTL  = 8'h10;
	localparam logic [7:0]  OFS_OPTION  = 8'h14;
	localparam logic [7:0]  OFS_PC      = 8'h18;
	localparam logic [7:0]  OFS_STACK   = 8'h1c;
	localparam logic [7:0]  OFS_FADDR   = 8'h20;
	localparam logic [7:0]  OFS_FDATA   = 8'h24;
	localparam logic [7:0]  OFS_CORE    = 8'h28;
	localparam logic [7:0]  OFS_WDOG    = 8'h2c;
	localparam int          ST_C        = 0;
	localparam int          ST_DC       = 1;
	localparam int          ST_Z        = 2;
	localparam int          ST_SLEEP    = 3;
	localparam int          ST_WDOG     = 4;
	localparam int          GIE_BIT     = 7;
	localparam logic [7:0]  RST_STATUS  = 8'h18;
	localparam logic [7:0]  RST_OPTION  = 8'hff;
	localparam logic [6:0]  OP_STORE    = 7'h01;
	localparam logic [13:0] OP_OPTION   = 14'h0062;
	localparam logic [13:0] OP_SLEEP    = 14'h0063;
	localparam logic [13:0] OP_IRQRET   = 14'h0009;
	localparam logic [13:0] OP_RET      = 14'h0008;
	localparam logic [5:0]  OP_DECSZ    = 6'h0b;
	localparam logic [5:0]  OP_INCSZ    = 6'h0f;
	localparam logic [5:0]  OP_INC      = 6'h0a;
	localparam logic [5:0]  OP_ORF      = 6'h04;
	localparam logic [5:0]  OP_COPY     = 6'h08;
	localparam logic [5:0]  OP_RLF      = 6'h0d;
	localparam logic [5:0]  OP_RRF      = 6'h0c;
	localparam logic [5:0]  OP_SUBF     = 6'h02;
	localparam logic [5:0]  OP_SWAP     = 6'h0e;
	localparam logic [5:0]  OP_ORL      = 6'h38;
	localparam logic [2:0]  OP_JUMP     = 3'h5;
	localparam logic [3:0]  OP_LOADL    = 4'hc;
	localparam logic [3:0]  OP_RETL     = 4'hd;
	localparam logic [4:0]  OP_SUBL     = 5'h1e;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {CS_RUN = 3'b001, CS_SECOND = 3'b010, CS_SLEEP = 3'b100} cies_core_t;
endpackage

// *** include/cies_if.sv ***
// Carriers between the core, its decoder and its bus slave.
`timescale 1ns/100ps
interface cies_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic        wr_err;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_err;
	logic        stall;
	modport slave (output wr_en, wr_addr, wr_data, rd_addr, input wr_err, rd_data, rd_err, stall);
	modport core (input wr_en, wr_addr, wr_data, rd_addr, output wr_err, rd_data, rd_err, stall);
endinterface
interface cies_alu_if;
	logic [13:0] instr;
	logic [7:0]  acc;
	logic [7:0]  fval;
	logic        cin;
	logic [7:0]  res;
	logic        wr_acc, wr_file, upd_z, upd_c, upd_dc, z, c, dc;
	logic        skip, jump, ret, set_gie, sleep, opt_load, two_cycle;
	modport alu (input instr, acc, fval, cin, output res, wr_acc, wr_file, upd_z, upd_c,
		upd_dc, z, c, dc, skip, jump, ret, set_gie, sleep, opt_load, two_cycle);
	modport core (output instr, acc, fval, cin, input res, wr_acc, wr_file, upd_z, upd_c,
		upd_dc, z, c, dc, skip, jump, ret, set_gie, sleep, opt_load, two_cycle);
endinterface

// *** src/cies_alu.sv ***
// Instruction decoder and arithmetic unit for the execute subset.
`timescale 1ns/100ps
module cies_alu
	import cies_pkg::*;
(
	cies_alu_if.alu a
);
	logic [7:0] f, k, x;
	logic [8:0] diff;
	logic [4:0] hdiff;
	logic       routed;

	always_comb begin
		f = a.fval;
		k = a.instr[7:0];
		x = (a.instr[13:12] == 2'b11) ? k : f;
		// Subtraction adds the inverted accumulator plus one, so carry means no borrow.
		diff = {1'b0, x} + {1'b0, ~a.acc} + 9'h001;
		hdiff = {1'b0, x[3:0]} + {1'b0, ~a.acc[3:0]} + 5'h01;
		routed = 1'b0;
		a.res = 8'h00;
		a.wr_acc = 1'b0;
		a.wr_file = 1'b0;
		a.upd_z = 1'b0;
		a.upd_c = 1'b0;
		a.upd_dc = 1'b0;
		a.c = a.cin;
		a.dc = 1'b0;
		a.skip = 1'b0;
		a.jump = 1'b0;
		a.ret = 1'b0;
		a.set_gie = 1'b0;
		a.sleep = 1'b0;
		a.opt_load = 1'b0;
		a.two_cycle = 1'b0;
		if (a.instr[13:7] == OP_STORE) begin
			a.res = a.acc; // see RULE9
			a.wr_file = 1'b1;
		end else if (a.instr == OP_OPTION) begin
			a.opt_load = 1'b1; // see RULE10
		end else if (a.instr == OP_SLEEP) begin
			a.sleep = 1'b1; // see RULE16
		end else if (a.instr == OP_IRQRET || a.instr == OP_RET) begin
			a.ret = 1'b1; // see RULE11 see RULE13
			a.set_gie = (a.instr == OP_IRQRET);
			a.two_cycle = 1'b1;
		end else if (a.instr[13:8] == OP_DECSZ || a.instr[13:8] == OP_INCSZ) begin
			a.res = (a.instr[10]) ? f + 8'h01 : f - 8'h01; // see RULE1 see RULE3
			a.skip = (a.res == 8'h00); // see RULE2
			routed = 1'b1;
		end else if (a.instr[13:8] == OP_INC) begin
			a.res = f + 8'h01; // see RULE3
			a.upd_z = 1'b1;
			routed = 1'b1;
		end else if (a.instr[13:8] == OP_ORF || a.instr[13:8] == OP_COPY) begin
			a.res = (a.instr[11]) ? f : (f | a.acc); // see RULE7 see RULE8
			a.upd_z = 1'b1;
			routed = 1'b1;
		end else if (a.instr[13:8] == OP_RLF || a.instr[13:8] == OP_RRF) begin
			a.res = (a.instr[8]) ? {f[6:0], a.cin} : {a.cin, f[7:1]}; // see RULE14 see RULE15
			a.c = (a.instr[8]) ? f[7] : f[0];
			a.upd_c = 1'b1;
			routed = 1'b1;
		end else if (a.instr[13:8] == OP_SUBF || a.instr[13:9] == OP_SUBL) begin
			a.res = diff[7:0]; // see RULE17 see RULE18
			a.c = diff[8];
			a.dc = hdiff[4];
			a.upd_c = 1'b1;
			a.upd_dc = 1'b1;
			a.upd_z = 1'b1;
			routed = (a.instr[13:8] == OP_SUBF);
			a.wr_acc = !routed;
		end else if (a.instr[13:8] == OP_SWAP) begin
			a.res = {f[3:0], f[7:4]}; // see RULE19
			routed = 1'b1;
		end else if (a.instr[13:11] == OP_JUMP) begin
			a.jump = 1'b1; // see RULE4
			a.two_cycle = 1'b1;
		end else if (a.instr[13:8] == OP_ORL) begin
			a.res = a.acc | k; // see RULE5
			a.wr_acc = 1'b1;
			a.upd_z = 1'b1;
		end else if (a.instr[13:10] == OP_LOADL || a.instr[13:10] == OP_RETL) begin
			a.res = k; // see RULE6 see RULE12
			a.wr_acc = 1'b1;
			a.ret = (a.instr[13:10] == OP_RETL);
			a.two_cycle = a.ret;
		end
		if (routed) begin
			a.wr_acc = !a.instr[7]; // see RULE20
			a.wr_file = a.instr[7];
		end
		a.z = (a.res == 8'h00);
	end
endmodule // cies_alu

// *** src/cies_axi_slave.sv ***
// AXI4-Lite slave front end that hands single-word accesses to the core.
`timescale 1ns/100ps
module cies_axi_slave
	import cies_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [AXI_AW-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [AXI_AW-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	cies_reg_if.slave              r
);
	logic        wr_take, rd_take, bvalid_d, rvalid_d;
	logic [1:0]  bresp_d, rresp_d;
	logic [31:0] rdata_d;

	// Address and data are taken together; a stalled core simply holds off both.
	assign wr_take = awvalid && wvalid && !bvalid && !r.stall;
	assign awready = wr_take;
	assign wready = wr_take;
	// Writes that miss either of the two low byte lanes are acknowledged but have no effect.
	assign r.wr_en = wr_take && (wstrb[1:0] == 2'b11);
	assign r.wr_addr = awaddr;
	assign r.wr_data = wdata;
	assign rd_take = arvalid && !rvalid;
	assign arready = rd_take;
	assign r.rd_addr = araddr;

	always_comb begin
		bvalid_d = bvalid && !bready;
		bresp_d = bresp;
		rvalid_d = rvalid && !rready;
		rresp_d = rresp;
		rdata_d = rdata;
		if (wr_take) begin
			bvalid_d = 1'b1;
			bresp_d = r.wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (rd_take) begin
			rvalid_d = 1'b1;
			rdata_d = r.rd_data;
			rresp_d = r.rd_err ? RESP_SLVERR : RESP_OKAY;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			bvalid <= bvalid_d;
			bresp <= bresp_d;
			rvalid <= rvalid_d;
			rresp <= rresp_d;
			rdata <= rdata_d;
		end
	end
endmodule // cies_axi_slave

// *** src/cies_exec_top.sv ***
// Execute core for a subset of a 14-bit instruction set, driven over AXI4-Lite.
//
// Overview of operation
// (RULE1) Decrement-and-skip subtracts one, routes by destination bit, leaves flags alone.
// (RULE2) A zero skip result discards the next instruction, running it as idle.
// (RULE3) Increment-and-skip adds one without flags; plain increment updates zero only.
// (RULE4) Jump loads eleven bits into the counter, page latch fills top two.
// (RULE5) OR-with-literal leaves accumulator OR literal in accumulator, sets zero flag.
// (RULE6) Load-literal copies the literal to the accumulator; don't-care bits ignored.
// (RULE7) OR-with-file ORs accumulator and file, routes result, updates zero flag.
// (RULE8) Copy-file moves a file register to its destination and updates zero.
// (RULE9) Store-accumulator writes the accumulator into the file, flags untouched.
// (RULE10) Option-load copies the accumulator into the prescaler configuration register.
// (RULE11) Interrupt return pops the stack, sets global enable, takes two cycles.
// (RULE12) Return-with-literal loads the literal and pops the stack in two cycles.
// (RULE13) Subroutine return pops the stack into the counter in two cycles.
// (RULE14) Rotate-left goes through carry; old bit seven becomes the carry.
// (RULE15) Rotate-right goes through carry; old bit zero becomes the carry.
// (RULE16) Sleep clears power-down, sets timeout, clears watchdog, then halts.
// (RULE17) Literal-minus-accumulator sets carry, half borrow and zero; carry means non-negative.
// (RULE18) File-minus-accumulator subtracts, routes by destination, updates three flags.
// (RULE19) Nibble exchange swaps the file nibbles, routes result, changes no flag.
// (RULE20) Low seven opcode bits address the file; bit seven selects destination.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module cies_exec_top
	import cies_pkg::*;
#(
	parameter int STACK_DEPTH = 8,
	parameter int WDOG_PRE_W  = 8
)(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   core_asleep,
	output logic                   global_irq_enable,
	output logic [7:0]             option_cfg
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	cies_reg_if rif ();
	cies_alu_if aif ();

	cies_axi_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.r       (rif)
	);

	cies_alu u_alu (
		.a (aif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Architectural state.

	cies_core_t       state_q, state_d;
	logic [7:0]       acc_q, acc_d, status_q, status_d, irqctl_q, irqctl_d;
	logic [7:0]       option_q, option_d, wdt_q, wdt_d;
	logic [4:0]       page_q, page_d;
	logic [12:0]      pc_q, pc_d, stack_top;
	logic [13:0]      instr_q, instr_d, iw;
	logic [6:0]       faddr_q, faddr_d, fw_addr;
	logic [7:0]       fw_data;
	logic             fw_en, skip_q, skip_d, push_en, issue, run;
	logic [SP_W-1:0]  sp_q, sp_d;
	logic [12:0]      push_val;
	logic [WDOG_PRE_W-1:0] wpre_q, wpre_d;
	logic [7:0]       fmem [FILE_DEPTH];
	logic [12:0]      stack_q [STACK_DEPTH];

	assign iw = rif.wr_data[13:0];
	assign issue = rif.wr_en && (rif.wr_addr == OFS_INSTR) && (state_q == CS_RUN);
	// A pending skip turns the next issued word into an idle slot.
	assign run = issue && !skip_q; // see RULE2
	assign stack_top = stack_q[sp_q - 1'b1];
	assign rif.stall = (state_q == CS_SECOND);
	assign aif.instr = iw;
	assign aif.acc = acc_q;
	assign aif.fval = fmem[iw[6:0]]; // see RULE20
	assign aif.cin = status_q[ST_C];

	assign core_asleep = (state_q == CS_SLEEP);
	assign global_irq_enable = irqctl_q[GIE_BIT];
	assign option_cfg = option_q;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic: execution first, then plain register writes.

	always_comb begin
		state_d = state_q;
		acc_d = acc_q;
		status_d = status_q;
		irqctl_d = irqctl_q;
		option_d = option_q;
		page_d = page_q;
		pc_d = pc_q;
		instr_d = instr_q;
		faddr_d = faddr_q;
		skip_d = skip_q;
		sp_d = sp_q;
		fw_en = 1'b0;
		fw_addr = faddr_q;
		fw_data = rif.wr_data[7:0];
		push_en = 1'b0;
		push_val = rif.wr_data[12:0];
		// The watchdog keeps counting so software can watch it run between sleeps.
		wpre_d = wpre_q + 1'b1;
		wdt_d = (wpre_q == '1) ? wdt_q + 8'h01 : wdt_q;
		if (state_q == CS_SECOND) begin
			state_d = CS_RUN;
		end
		if (issue) begin
			instr_d = iw;
			pc_d = pc_q + 13'h0001;
			skip_d = 1'b0; // see RULE2
		end
		if (run) begin
			skip_d = aif.skip; // see RULE2
			if (aif.wr_acc) begin
				acc_d = aif.res;
			end
			if (aif.wr_file) begin
				fw_en = 1'b1; // see RULE9
				fw_addr = iw[6:0];
				fw_data = aif.res;
			end
			if (aif.upd_z) begin
				status_d[ST_Z] = aif.z;
			end
			if (aif.upd_c) begin
				status_d[ST_C] = aif.c;
			end
			if (aif.upd_dc) begin
				status_d[ST_DC] = aif.dc;
			end
			if (aif.jump) begin
				pc_d = {page_q[4:3], iw[10:0]}; // see RULE4
			end
			if (aif.ret) begin
				pc_d = stack_top; // see RULE11 see RULE12 see RULE13
				sp_d = sp_q - 1'b1;
			end
			if (aif.set_gie) begin
				irqctl_d[GIE_BIT] = 1'b1; // see RULE11
			end
			if (aif.opt_load) begin
				option_d = acc_q; // see RULE10
			end
			if (aif.two_cycle) begin
				state_d = CS_SECOND;
			end
			if (aif.sleep) begin
				status_d[ST_SLEEP] = 1'b0; // see RULE16
				status_d[ST_WDOG] = 1'b1;
				wpre_d = '0;
				wdt_d = 8'h00;
				state_d = CS_SLEEP;
			end
		end
		if (rif.wr_en) begin
			if (rif.wr_addr == OFS_ACC) begin
				acc_d = rif.wr_data[7:0];
			end else if (rif.wr_addr == OFS_STATUS) begin
				status_d = {3'h0, rif.wr_data[4:0]};
			end else if (rif.wr_addr == OFS_PAGE) begin
				page_d = rif.wr_data[4:0];
			end else if (rif.wr_addr == OFS_IRQCTL) begin
				irqctl_d = rif.wr_data[7:0];
			end else if (rif.wr_addr == OFS_OPTION) begin
				option_d = rif.wr_data[7:0];
			end else if (rif.wr_addr == OFS_STACK) begin
				push_en = 1'b1;
				sp_d = sp_q + 1'b1;
			end else if (rif.wr_addr == OFS_FADDR) begin
				faddr_d = rif.wr_data[6:0];
			end else if (rif.wr_addr == OFS_FDATA) begin
				fw_en = 1'b1;
			end else if (rif.wr_addr == OFS_CORE && rif.wr_data[0] && state_q == CS_SLEEP) begin
				state_d = CS_RUN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	always_comb begin
		rif.wr_err = 1'b0;
		if (rif.wr_addr[1:0] != 2'b00 || rif.wr_addr > OFS_WDOG) begin
			rif.wr_err = 1'b1;
		end
		rif.rd_err = 1'b0;
		rif.rd_data = 32'h0000_0000;
		if (rif.rd_addr == OFS_INSTR) begin
			rif.rd_data = {18'h0, instr_q};
		end else if (rif.rd_addr == OFS_ACC) begin
			rif.rd_data = {24'h0, acc_q};
		end else if (rif.rd_addr == OFS_STATUS) begin
			rif.rd_data = {24'h0, status_q};
		end else if (rif.rd_addr == OFS_PAGE) begin
			rif.rd_data = {27'h0, page_q};
		end else if (rif.rd_addr == OFS_IRQCTL) begin
			rif.rd_data = {24'h0, irqctl_q};
		end else if (rif.rd_addr == OFS_OPTION) begin
			rif.rd_data = {24'h0, option_q};
		end else if (rif.rd_addr == OFS_PC) begin
			rif.rd_data = {19'h0, pc_q};
		end else if (rif.rd_addr == OFS_STACK) begin
			rif.rd_data = {19'h0, stack_top};
		end else if (rif.rd_addr == OFS_FADDR) begin
			rif.rd_data = {25'h0, faddr_q};
		end else if (rif.rd_addr == OFS_FDATA) begin
			rif.rd_data = {24'h0, fmem[faddr_q]};
		end else if (rif.rd_addr == OFS_CORE) begin
			rif.rd_data = {24'h0, 3'h0, 4'(sp_q), skip_q};
		end else if (rif.rd_addr == OFS_WDOG) begin
			rif.rd_data = {24'h0, wdt_q};
		end else begin
			rif.rd_err = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= CS_RUN;
			acc_q <= 8'h00;
			status_q <= RST_STATUS;
			irqctl_q <= 8'h00;
			option_q <= RST_OPTION;
			page_q <= 5'h00;
			pc_q <= 13'h0000;
			instr_q <= 14'h0000;
			faddr_q <= 7'h00;
			skip_q <= 1'b0;
			sp_q <= '0;
			wpre_q <= '0;
			wdt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			acc_q <= acc_d;
			status_q <= status_d;
			irqctl_q <= irqctl_d;
			option_q <= option_d;
			page_q <= page_d;
			pc_q <= pc_d;
			instr_q <= instr_d;
			faddr_q <= faddr_d;
			skip_q <= skip_d;
			sp_q <= sp_d;
			wpre_q <= wpre_d;
			wdt_q <= wdt_d;
		end
	end

	// The file and stack arrays have no reset; software must initialise what it reads.
	always_ff @(posedge aclk) begin
		if (fw_en) begin
			fmem[fw_addr] <= fw_data;
		end
		if (push_en) begin
			stack_q[sp_q] <= push_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_zero_skip;
		run && (iw[13:8] == OP_DECSZ || iw[13:8] == OP_INCSZ) && aif.res == 8'h00;
	endsequence
	sequence s_idle_slot;
		issue && skip_q;
	endsequence

	property p_dec_acc;
		run && iw[13:8] == OP_DECSZ && !iw[7]
			|=> acc_q == $past(aif.fval) - 8'h01 && status_q == $past(status_q);
	endproperty
	a_dec_acc: assert property (p_dec_acc) else $error("decrement result wrong"); // see RULE1
	property p_skip;
		s_idle_slot |=> acc_q == $past(acc_q) && !skip_q;
	endproperty
	a_skip: assert property (p_skip) else $error("skipped word was executed"); // see RULE2
	property p_skip_arm;
		s_zero_skip |=> skip_q;
	endproperty
	a_skip_arm: assert property (p_skip_arm) else $error("skip not armed"); // see RULE2
	property p_inc_z;
		run && iw[13:8] == OP_INC |=> status_q[ST_Z] == ($past(aif.res) == 8'h00);
	endproperty
	a_inc_z: assert property (p_inc_z) else $error("increment zero flag wrong"); // see RULE3
	property p_jump;
		run && iw[13:11] == OP_JUMP |=> pc_q == {$past(page_q[4:3]), $past(iw[10:0])}
			&& state_q == CS_SECOND ##1 state_q == CS_RUN;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target or length wrong"); // see RULE4
	property p_orl;
		run && iw[13:8] == OP_ORL |=> acc_q == ($past(acc_q) | $past(iw[7:0]))
			&& status_q[ST_Z] == (acc_q == 8'h00);
	endproperty
	a_orl: assert property (p_orl) else $error("or literal wrong"); // see RULE5
	property p_loadl;
		run && iw[13:10] == OP_LOADL |=> acc_q == $past(iw[7:0]) && $stable(status_q);
	endproperty
	a_loadl: assert property (p_loadl) else $error("load literal wrong"); // see RULE6
	property p_store;
		run && iw[13:7] == OP_STORE |=> fmem[$past(iw[6:0])] == $past(acc_q);
	endproperty
	a_store: assert property (p_store) else $error("store accumulator wrong"); // see RULE9
	property p_irqret;
		run && iw == OP_IRQRET |=> irqctl_q[GIE_BIT] && pc_q == $past(stack_top)
			&& state_q == CS_SECOND;
	endproperty
	a_irqret: assert property (p_irqret) else $error("interrupt return wrong"); // see RULE11
	property p_sleep;
		run && iw == OP_SLEEP |=> !status_q[ST_SLEEP] && status_q[ST_WDOG] && core_asleep;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry wrong"); // see RULE16
	property p_subl;
		run && iw[13:9] == OP_SUBL |=> status_q[ST_C] == ($past(iw[7:0]) >= $past(acc_q));
	endproperty
	a_subl: assert property (p_subl) else $error("subtract carry wrong"); // see RULE17
	property p_swap;
		run && iw[13:8] == OP_SWAP && !iw[7]
			|=> acc_q == {$past(aif.fval[3:0]), $past(aif.fval[7:4])};
	endproperty
	a_swap: assert property (p_swap) else $error("nibble exchange wrong"); // see RULE19
endmodule // cies_exec_top

// *** sim/cies_axi_master.sv ***
// Bus master model that issues single AXI4-Lite transfers to the block.
`timescale 1ns/100ps
module cies_axi_master (
	input  wire logic   aclk,
	output logic [7:0]  s_axi_awaddr,
	output logic [2:0]  s_axi_awprot,
	output logic        s_axi_awvalid,
	input  wire logic   s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input  wire logic   s_axi_wready,
	input  wire logic [1:0] s_axi_bresp,
	input  wire logic   s_axi_bvalid,
	output logic        s_axi_bready,
	output logic [7:0]  s_axi_araddr,
	output logic [2:0]  s_axi_arprot,
	output logic        s_axi_arvalid,
	input  wire logic   s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0] s_axi_rresp,
	input  wire logic   s_axi_rvalid,
	output logic        s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // cies_axi_master

// *** sim/tb_cies_exec_top.sv ***
// Self-checking bench for the instruction execute subset.
`timescale 1ns/100ps
module tb_cies_exec_top import cies_pkg::*;;
	logic aclk = 0, aresetn = 0;
	wire logic [7:0] s_axi_awaddr, s_axi_araddr, option_cfg;
	wire logic [31:0] s_axi_wdata, s_axi_rdata;
	wire logic [3:0] s_axi_wstrb;
	wire logic [2:0] s_axi_awprot, s_axi_arprot;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	wire logic core_asleep, global_irq_enable;
	int n_mismatch, samples_checked, cyc, seed = 86463;
	logic [5:0] ops [13] = '{OP_DECSZ, OP_INCSZ, OP_INC, OP_ORF, OP_COPY, OP_RLF, OP_RRF,
		OP_SUBF, OP_SWAP, 6'h00, OP_ORL, {OP_LOADL, 2'b00}, {OP_SUBL, 1'b0}};
	always #12.5 aclk = ~aclk;
	cies_exec_top cies_exec_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .core_asleep, .global_irq_enable, .option_cfg);
	cies_axi_master cies_axi_master_inst (.*);
	////////////////////////////////////////////////////////////////////////////
	// Expected status over the expected result byte.
	function automatic logic [12:0] ex(input logic [5:0] op, input logic [7:0] f, a,
		input logic [4:0] s);
		logic [8:0] t;
		logic [4:0] h;
		logic [7:0] r;
		t = {1'b0, f} + {1'b0, ~a} + 9'h1;
		h = {1'b0, f[3:0]} + {1'b0, ~a[3:0]} + 5'h1;
		case (op)
			OP_DECSZ: r = f - 8'h1;
			OP_INCSZ, OP_INC: r = f + 8'h1;
			OP_ORF, OP_ORL: r = f | a;
			OP_RLF: r = {f[6:0], s[ST_C]};
			OP_RRF: r = {s[ST_C], f[7:1]};
			OP_SUBF, 6'h3c: r = t[7:0];
			OP_SWAP: r = {f[3:0], f[7:4]};
			6'h00: r = a;
			default: r = f;
		endcase
		if (op inside {OP_INC, OP_ORF, OP_ORL, OP_COPY, OP_SUBF, 6'h3c}) s[ST_Z] = r == 8'h0;
		if (op inside {OP_SUBF, 6'h3c}) {s[ST_DC], s[ST_C]} = {h[4], t[8]};
		if (op == OP_RLF) s[ST_C] = f[7];
		if (op == OP_RRF) s[ST_C] = f[0];
		return {s, r};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		cies_axi_master_inst.wr(a, d, r);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		cies_axi_master_inst.rd(a, d, r);
		chk(nm, e, d);
		chk("rresp", a > OFS_WDOG ? RESP_SLVERR : RESP_OKAY, 32'(r));
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] f, a, k, ad;
		logic [4:0] s;
		logic [12:0] e, v;
		logic [13:0] in;
		logic [5:0] op;
		logic [1:0] br;
		logic d, lit, sk;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rc("status reset", OFS_STATUS, 32'(RST_STATUS));
		chk("option reset", 32'(RST_OPTION), 32'(option_cfg));
		for (int i = 0; i < 130; i++) begin
			op = ops[i % 13];
			f = i < 13 ? 8'h01 : (i < 26 ? 8'hff : 8'($random(seed)));
			a = $random(seed);
			s = RST_STATUS[4:0] | 5'($random(seed) & 7);
			ad = 8'($random(seed) & 8'h7f);
			lit = op[5:4] == 2'b11;
			d = i[0] | op == 6'h00;
			sk = op == OP_DECSZ || op == OP_INCSZ;
			in = 14'($random(seed)) & (op == 6'h30 ? 14'h0300 : (op == 6'h3c ? 14'h0100 : 14'h0));
			in = lit ? in | {op, f} : {op, d, ad[6:0]};
			e = ex(op, f, a, s);
			w(OFS_STATUS, s);
			w(OFS_ACC, a);
			w(OFS_FADDR, ad);
			w(OFS_FDATA, f);
			w(OFS_INSTR, in);
			if (sk) w(OFS_INSTR, {OP_LOADL, 2'b00, 8'h5a});
			rc("acc", OFS_ACC, sk && e[7:0] != 0 ? 8'h5a : (lit | !d ? e[7:0] : a));
			rc("file", OFS_FDATA, !lit && d ? e[7:0] : f);
			rc("status", OFS_STATUS, e[12:8]);
			$display("test %0d done", i);
		end
		for (int i = 0; i < 4; i++) begin
			v = 13'($random(seed));
			k = $random(seed);
			w(OFS_PAGE, i * 8);
			w(OFS_IRQCTL, 0);
			w(OFS_INSTR, {3'h5, v[10:0]});
			rc("pc jump", OFS_PC, {i[1:0], v[10:0]});
			w(OFS_STACK, v);
			w(OFS_INSTR, i[0] ? {OP_RETL, 2'b00, k} : (i[1] ? OP_IRQRET : OP_RET));
			rc("pc return", OFS_PC, v);
			if (i[0]) rc("acc return", OFS_ACC, k);
			chk("irq enable", i == 2, global_irq_enable);
			rc("status return", OFS_STATUS, e[12:8]);
			$display("test jump and return %0d done", i);
		end
		w(OFS_ACC, k);
		w(OFS_INSTR, OP_OPTION);
		chk("option", k, option_cfg);
		w(OFS_STATUS, 5'h0d);
		repeat (600) @(posedge aclk);
		w(OFS_INSTR, OP_SLEEP);
		chk("asleep", 1, core_asleep);
		rc("status sleep", OFS_STATUS, 5'h15);
		rc("watchdog", OFS_WDOG, 0);
		w(OFS_CORE, 1);
		chk("awake", 0, core_asleep);
		cies_axi_master_inst.wr(8'h30, 0, br);
		chk("bresp", RESP_SLVERR, br);
		rc("unmapped", 8'h30, 0);
		$display("test sleep and bus done");
		close_out();
	end
endmodule // tb_cies_exec_top
